// file: hdl/irq_enable_mask.sv
// Interrupt enable mask with set and clear views behind an AXI4-Lite slave
// What this block does
// - Clear view: writing one to bit 2 disables slow RC ready interrupt.
// - Writing zero to any enable bit in either view changes nothing.
// - Set view sits at 0x04, resets to zero, write-protected.
// - Set view bit 11 enables brown-out sync ready interrupt.
// - Set view bit 10 enables brown-out detection interrupt.
// - Set view bit 9 enables brown-out ready interrupt.
// - Set view bit 8 enables FLL reference stopped interrupt.
// - Set view bit 7 enables FLL coarse lock interrupt.
// - Set view bit 6 holds FLL fine lock enable.
// - Set view bit 5 enables FLL out-of-bounds interrupt.
// - Set view bit 4 enables FLL ready interrupt.
// - Bit 1 holds slow crystal ready enable; writing one sets it.
// - Bit 0 holds crystal ready enable; writing one sets it.
// - Source requests one cycle after its enable and flag are both one.
// - Set view bit 3 enables fast RC ready interrupt.
// - Flag sets on status rising edge, clears on written one.
module irq_enable_mask (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [11:0] src_status,
  output logic [11:0]      irq_req,
  output logic             irq
);
  localparam int unsigned NS = sysctrl_irq_pkg::NUM_SRC;

  sysctrl_irq_pkg::wr_state_e state_q;
  sysctrl_irq_pkg::wr_state_e state_d;

  logic        aw_have_q;
  logic        aw_have_d;
  logic        w_have_q;
  logic        w_have_d;
  logic [7:0]  waddr_q;
  logic [7:0]  waddr_d;
  logic [31:0] wdata_q;
  logic [31:0] wdata_d;
  logic [3:0]  wstrb_q;
  logic [3:0]  wstrb_d;
  logic        awready_q;
  logic        awready_d;
  logic        wready_q;
  logic        wready_d;
  logic        bvalid_q;
  logic        bvalid_d;
  logic [1:0]  bresp_q;
  logic [1:0]  bresp_d;

  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  logic [NS-1:0] en_q;
  logic [NS-1:0] en_d;
  logic          wprot_q;
  logic [NS-1:0] irq_req_q;
  logic          irq_q;

  flag_if #(.N(NS)) fl ();

  src_sync #(.N(NS)) u_sync (
    .clk   (aclk),
    .rst_n (aresetn),
    .raw   (src_status),
    .port  (fl)
  );

  irq_flags #(.N(NS)) u_flags (
    .clk   (aclk),
    .rst_n (aresetn),
    .port  (fl)
  );

  // Write decode
  logic [31:0]   wmask;
  logic [31:0]   wdata_m;
  logic          wr_fire;
  logic          hit_set;
  logic          hit_clr;
  logic          hit_flag;
  logic          hit_wprot;
  logic          hit_stat;
  logic          wr_mapped;
  logic          wr_blocked;
  logic          en_set_wr;
  logic          en_clr_wr;
  logic [NS-1:0] set_bits;
  logic [NS-1:0] clr_bits;
  logic [NS-1:0] req_now;

  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wmask[8*b +: 8] = {8{wstrb_q[b]}};
  end

  assign wdata_m   = wdata_q & wmask;
  assign wr_fire   = (state_q == sysctrl_irq_pkg::WR_EXEC);
  assign hit_set   = (waddr_q == sysctrl_irq_pkg::OFS_EN_SET);
  assign hit_clr   = (waddr_q == sysctrl_irq_pkg::OFS_EN_CLR);
  assign hit_flag  = (waddr_q == sysctrl_irq_pkg::OFS_FLAG);
  assign hit_wprot = (waddr_q == sysctrl_irq_pkg::OFS_WPROT);
  assign hit_stat  = (waddr_q == sysctrl_irq_pkg::OFS_STATUS);
  assign wr_mapped = hit_set | hit_clr | hit_flag | hit_wprot | hit_stat;
  // Protection locks both views of the mask, not the flags
  assign wr_blocked = wprot_q & (hit_set | hit_clr);
  assign en_set_wr  = wr_fire & hit_set & ~wprot_q;
  assign en_clr_wr  = wr_fire & hit_clr & ~wprot_q;
  // Only the low bits exist, upper write data falls away
  assign set_bits = en_set_wr ? wdata_m[NS-1:0] : '0;
  assign clr_bits = en_clr_wr ? wdata_m[NS-1:0] : '0;
  assign fl.clear = (wr_fire & hit_flag) ? wdata_m[NS-1:0] : '0;

  // Zeros in either view leave the bit alone; one shared mask
  // Bit i of the written word acts on enable i, for every source
  assign en_d = (en_q | set_bits) & ~clr_bits;
  assign req_now = en_q & fl.flags;

  // Write channel sequencing
  always_comb begin
    state_d   = state_q;
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    waddr_d   = waddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    case (state_q)
      sysctrl_irq_pkg::WR_IDLE: begin
        if (awvalid && awready_q) begin
          aw_have_d = 1'b1;
          waddr_d   = awaddr[7:0];
        end
        if (wvalid && wready_q) begin
          w_have_d = 1'b1;
          wdata_d  = wdata;
          wstrb_d  = wstrb;
        end
        if (aw_have_d && w_have_d) begin
          state_d = sysctrl_irq_pkg::WR_EXEC;
        end
      end
      sysctrl_irq_pkg::WR_EXEC: begin
        aw_have_d = 1'b0;
        w_have_d  = 1'b0;
        bvalid_d  = 1'b1;
        bresp_d   = (wr_mapped && !wr_blocked) ?
                    sysctrl_irq_pkg::RESP_OKAY : sysctrl_irq_pkg::RESP_SLVERR;
        state_d   = sysctrl_irq_pkg::WR_RESP;
      end
      sysctrl_irq_pkg::WR_RESP: begin
        if (bready) begin
          bvalid_d = 1'b0;
          state_d  = sysctrl_irq_pkg::WR_IDLE;
        end
      end
      default: begin
        state_d = sysctrl_irq_pkg::WR_IDLE;
      end
    endcase
    awready_d = (state_d == sysctrl_irq_pkg::WR_IDLE) && !aw_have_d;
    wready_d  = (state_d == sysctrl_irq_pkg::WR_IDLE) && !w_have_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q   <= sysctrl_irq_pkg::WR_IDLE;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      waddr_q   <= 8'h00;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
    end else begin
      state_q   <= state_d;
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      waddr_q   <= waddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  // Read decode; reads have no side effects
  logic [7:0]  rd_addr;
  logic        rd_is_en;
  logic        rd_hit;
  logic [31:0] rd_word;
  logic        ar_take;
  logic        r_done;

  assign rd_addr  = araddr[7:0];
  assign rd_is_en = (rd_addr == sysctrl_irq_pkg::OFS_EN_SET) ||
                    (rd_addr == sysctrl_irq_pkg::OFS_EN_CLR);
  assign rd_hit   = rd_is_en ||
                    (rd_addr == sysctrl_irq_pkg::OFS_FLAG) ||
                    (rd_addr == sysctrl_irq_pkg::OFS_STATUS) ||
                    (rd_addr == sysctrl_irq_pkg::OFS_WPROT);
  assign rd_word  =
    rd_is_en ? {{(32-NS){1'b0}}, en_q} :
    (rd_addr == sysctrl_irq_pkg::OFS_FLAG) ? {{(32-NS){1'b0}}, fl.flags} :
    (rd_addr == sysctrl_irq_pkg::OFS_STATUS) ? {{(32-NS){1'b0}}, fl.level} :
    (rd_addr == sysctrl_irq_pkg::OFS_WPROT) ? {31'h00000000, wprot_q} :
    32'h00000000;
  assign ar_take  = arvalid && arready_q;
  assign r_done   = rvalid_q && rready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= 2'h0;
    end else begin
      arready_q <= !(ar_take || (rvalid_q && !rready));
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_word;
        rresp_q  <= rd_hit ? sysctrl_irq_pkg::RESP_OKAY :
                             sysctrl_irq_pkg::RESP_SLVERR;
      end else if (r_done) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Mask, protection and request registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q      <= sysctrl_irq_pkg::EN_RESET;
      wprot_q   <= sysctrl_irq_pkg::WPROT_RESET;
      irq_req_q <= '0;
      irq_q     <= 1'b0;
    end else begin
      en_q      <= en_d;
      if (wr_fire && hit_wprot) begin
        wprot_q <= wdata_m[0];
      end
      irq_req_q <= req_now;
      irq_q     <= |req_now;
    end
  end

  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;
  assign irq_req = irq_req_q;
  assign irq     = irq_q;

  // Checks
  logic rd_en_view_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_en_view_q <= 1'b0;
    end else if (ar_take) begin
      rd_en_view_q <= rd_is_en;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_set_bit(int unsigned b);
    en_set_wr && set_bits[b] |=> en_q[b];
  endproperty

  a_clear_bit2: assert property (
    en_clr_wr && clr_bits[sysctrl_irq_pkg::INT_SLOW_RC_READY_IE]
    |=> !en_q[sysctrl_irq_pkg::INT_SLOW_RC_READY_IE])
    else $error("clear view bit 2 did not disable");
  a_set_zero_keep: assert property (
    en_set_wr |=> (en_q & ~$past(set_bits)) ==
                  ($past(en_q) & ~$past(set_bits)))
    else $error("zero in set view changed an enable");
  a_clr_zero_keep: assert property (
    en_clr_wr |=> (en_q | $past(clr_bits)) ==
                  ($past(en_q) | $past(clr_bits)))
    else $error("zero in clear view changed an enable");
  a_protect_hold: assert property (
    wr_fire && wr_blocked |=> $stable(en_q) && bvalid_q &&
    bresp_q == sysctrl_irq_pkg::RESP_SLVERR)
    else $error("protected write altered the mask");
  a_set_b11: assert property (
    p_set_bit(sysctrl_irq_pkg::BROWNOUT_SYNC_READY_IE))
    else $error("bit 11 not enabled");
  a_set_b10: assert property (
    p_set_bit(sysctrl_irq_pkg::BROWNOUT_DETECT_IE))
    else $error("bit 10 not enabled");
  a_set_b9: assert property (
    p_set_bit(sysctrl_irq_pkg::BROWNOUT_READY_IE))
    else $error("bit 9 not enabled");
  a_set_b8: assert property (
    p_set_bit(sysctrl_irq_pkg::FLL_REF_STOPPED_IE))
    else $error("bit 8 not enabled");
  a_set_b7: assert property (
    p_set_bit(sysctrl_irq_pkg::FLL_COARSE_LOCK_IE))
    else $error("bit 7 not enabled");
  a_set_b6: assert property (
    p_set_bit(sysctrl_irq_pkg::FLL_FINE_LOCK_IE))
    else $error("bit 6 not enabled");
  a_set_b5: assert property (
    p_set_bit(sysctrl_irq_pkg::FLL_OUT_OF_BOUNDS_IE))
    else $error("bit 5 not enabled");
  a_set_b4: assert property (
    p_set_bit(sysctrl_irq_pkg::FLL_READY_IE))
    else $error("bit 4 not enabled");
  a_set_b1: assert property (
    p_set_bit(sysctrl_irq_pkg::SLOW_CRYSTAL_READY_IE))
    else $error("bit 1 not enabled");
  a_set_b0: assert property (
    p_set_bit(sysctrl_irq_pkg::CRYSTAL_READY_IE))
    else $error("bit 0 not enabled");
  a_set_b3: assert property (
    p_set_bit(sysctrl_irq_pkg::FAST_RC_READY_IE))
    else $error("bit 3 not enabled");
  a_req_gate: assert property (
    1'b1 |=> irq_req_q == ($past(en_q) & $past(fl.flags)) &&
             irq_q == (irq_req_q != '0))
    else $error("request does not follow enable and flag");
  a_req_masked: assert property (
    (en_q == '0) [*2] |-> irq_req_q == '0 && !irq_q)
    else $error("masked source requested");
  a_flag_edge: assert property (
    fl.rise != '0 |=> (fl.flags & $past(fl.rise)) == $past(fl.rise))
    else $error("edge did not set its flag");
  a_flag_clear: assert property (
    (fl.clear & ~fl.rise) != '0 |=>
    (fl.flags & $past(fl.clear) & ~$past(fl.rise)) == '0)
    else $error("written one did not clear flag");
  a_view_read: assert property (
    ar_take && rd_is_en |=> rvalid_q && rdata_q[NS-1:0] == $past(en_q))
    else $error("enable view read mismatch");
  a_upper_zero: assert property (
    rvalid_q && rd_en_view_q |-> rdata_q[31:NS] == '0)
    else $error("unimplemented enable bits read non-zero");
  a_write_timing: assert property (
    wr_fire |=> bvalid_q && state_q == sysctrl_irq_pkg::WR_RESP)
    else $error("write response missing");
  a_both_taken: assert property (
    awvalid && awready_q && wvalid && wready_q |-> ##2 bvalid_q)
    else $error("write response late");

  c_set_write: cover property (en_set_wr && set_bits != '0);
  c_clr_write: cover property (en_clr_wr && clr_bits != '0);
  c_irq_rise: cover property ($rose(irq_q));
  c_protected: cover property (wr_fire && wr_blocked);
endmodule

// file: hdl/sysctrl_irq_pkg.sv
// Shared constants for the interrupt enable mask block
package sysctrl_irq_pkg;

  localparam int unsigned NUM_SRC = 12;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned ADDR_W  = 32;
  localparam int unsigned DEC_W   = 8;

  localparam logic [7:0] OFS_EN_CLR = 8'h00;
  localparam logic [7:0] OFS_EN_SET = 8'h04;
  localparam logic [7:0] OFS_FLAG   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_WPROT  = 8'h10;

  localparam logic [11:0] EN_RESET    = 12'h000;
  localparam logic [11:0] FLAG_RESET  = 12'h000;
  localparam logic        WPROT_RESET = 1'b0;

  localparam int unsigned CRYSTAL_READY_IE        = 0;
  localparam int unsigned SLOW_CRYSTAL_READY_IE   = 1;
  localparam int unsigned INT_SLOW_RC_READY_IE    = 2;
  localparam int unsigned FAST_RC_READY_IE        = 3;
  localparam int unsigned FLL_READY_IE            = 4;
  localparam int unsigned FLL_OUT_OF_BOUNDS_IE    = 5;
  localparam int unsigned FLL_FINE_LOCK_IE        = 6;
  localparam int unsigned FLL_COARSE_LOCK_IE      = 7;
  localparam int unsigned FLL_REF_STOPPED_IE      = 8;
  localparam int unsigned BROWNOUT_READY_IE       = 9;
  localparam int unsigned BROWNOUT_DETECT_IE      = 10;
  localparam int unsigned BROWNOUT_SYNC_READY_IE  = 11;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_EXEC = 3'b010,
    WR_RESP = 3'b100
  } wr_state_e;

endpackage

// file: hdl/flag_if.sv
// Bundle between the source synchroniser, the flag bank and the top
interface flag_if #(parameter int unsigned N = 12);
  logic [N-1:0] rise;
  logic [N-1:0] level;
  logic [N-1:0] clear;
  logic [N-1:0] flags;
  modport src (output rise, output level);
  modport flg (input rise, input clear, output flags);
endinterface

// file: hdl/src_sync.sv
// Three-stage synchroniser and rising-edge detect for source status pins
module src_sync #(
  parameter int unsigned N = 12
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] raw,
  flag_if.src               port
);
  logic [N-1:0] s1_q;
  logic [N-1:0] s2_q;
  logic [N-1:0] s3_q;
  logic [N-1:0] stable_q;
  logic [N-1:0] stable_d;
  logic [N-1:0] rise;

  if (N < 1 || N > 32) begin : g_chk
    $error("src_sync: N must lie in 1..32");
  end

  // A change only counts once stages two and three agree
  for (genvar i = 0; i < N; i++) begin : g_bit
    assign stable_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : stable_q[i];
    assign rise[i]     = (s2_q[i] == s3_q[i]) && s3_q[i] && !stable_q[i];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q     <= '0;
      s2_q     <= '0;
      s3_q     <= '0;
      stable_q <= '0;
    end else begin
      s1_q     <= raw;
      s2_q     <= s1_q;
      s3_q     <= s2_q;
      stable_q <= stable_d;
    end
  end

  assign port.rise  = rise;
  assign port.level = stable_q;
endmodule

// file: hdl/irq_flags.sv
// Sticky interrupt flags, set by a source edge, cleared by write-one
module irq_flags #(
  parameter int unsigned N = 12
) (
  input  wire logic clk,
  input  wire logic rst_n,
  flag_if.flg       port
);
  logic [N-1:0] flags_q;
  logic [N-1:0] flags_d;

  if (N < 1 || N > 32) begin : g_chk
    $error("irq_flags: N must lie in 1..32");
  end

  // A new edge in the clearing cycle wins, so no event is lost
  assign flags_d = port.rise | (flags_q & ~port.clear);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_q <= sysctrl_irq_pkg::FLAG_RESET[N-1:0];
    end else begin
      flags_q <= flags_d;
    end
  end

  assign port.flags = flags_q;
endmodule

// file: sim/sysctrl_interrupt_enable_mask_test.sv
// Self-checking bench for the interrupt enable mask block
module sysctrl_interrupt_enable_mask_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] A_CLR = 32'h0000_0000;
  localparam logic [31:0] A_SET = 32'h0000_0004;
  localparam logic [31:0] A_FLG = 32'h0000_0008;
  localparam logic [31:0] A_PRT = 32'h0000_0010;
  localparam logic [31:0] A_BAD = 32'h0000_0040;
  localparam logic [1:0]  OKAY  = sysctrl_irq_pkg::RESP_OKAY;
  localparam logic [1:0]  SLV   = sysctrl_irq_pkg::RESP_SLVERR;

  logic        aclk;
  logic        aresetn;
  logic [31:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [31:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [11:0] src_status;
  logic [11:0] irq_req;
  logic        irq;
  int          failures;
  int          tests_run;

  irq_enable_mask u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .src_status(src_status), .irq_req(irq_req), .irq(irq)
  );

  always #5 aclk = ~aclk;

  task automatic test_done();
    $display("Checks made %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic timed_out(input string what);
    failures++;
    $display("CHECK FAILED at %0t: no answer in %s", $time, what);
    test_done();
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp,
                            input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: resp got %h want %h", $time, got, exp);
    end
  endtask

  // Address and data offered together, each released once taken
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    int   n;
    logic aw_ok;
    logic w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      n++;
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
      if (n > 50) timed_out("write request");
    end
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (n > 50) timed_out("write response");
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_read(input logic [31:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (n > 50) timed_out("read request");
    end while (!arready);
    arvalid <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (n > 50) timed_out("read data");
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic read_check(input logic [31:0] a, input logic [31:0] exp,
                            input logic [1:0] exp_r);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check_resp(r, exp_r);
    check_word(d, exp, "read data");
  endtask

  task automatic write_check(input logic [31:0] a, input logic [31:0] d,
                             input logic [1:0] exp_r);
    logic [1:0] r;
    axi_write(a, d, r);
    check_resp(r, exp_r);
  endtask

  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq !== lvl) begin
      @(posedge aclk);
      n++;
      if (n > 20) timed_out("interrupt line");
    end
  endtask

  task automatic test_reset();
    read_check(A_SET, 32'h0000_0000, OKAY);
    read_check(A_CLR, 32'h0000_0000, OKAY);
    check_word({20'h0_0000, irq_req}, 32'h0000_0000, "irq_req");
    $display("Test reset values done");
  endtask

  task automatic test_set_bits();
    for (int i = 0; i < 12; i++) begin
      write_check(A_SET, 32'h1 << i, OKAY);
      read_check(A_SET, (32'h2 << i) - 32'h1, OKAY);
      read_check(A_CLR, (32'h2 << i) - 32'h1, OKAY);
    end
    write_check(A_SET, 32'hFFFF_FFFF, OKAY);
    read_check(A_SET, 32'h0000_0FFF, OKAY);
    write_check(A_SET, 32'h0000_0000, OKAY);
    read_check(A_SET, 32'h0000_0FFF, OKAY);
    $display("Test set view done");
  endtask

  task automatic test_clear_view();
    write_check(A_CLR, 32'h0000_0004, OKAY);
    read_check(A_SET, 32'h0000_0FFB, OKAY);
    write_check(A_CLR, 32'h0000_0000, OKAY);
    read_check(A_CLR, 32'h0000_0FFB, OKAY);
    check_word({20'h0_0000, irq_req}, 32'h0000_0000, "irq_req");
    $display("Test clear view done");
  endtask

  // Protected writes must leave the mask alone in both views
  task automatic test_protect();
    write_check(A_PRT, 32'h0000_0001, OKAY);
    write_check(A_SET, 32'h0000_0004, SLV);
    write_check(A_CLR, 32'h0000_0FFF, SLV);
    read_check(A_SET, 32'h0000_0FFB, OKAY);
    write_check(A_PRT, 32'h0000_0000, OKAY);
    write_check(A_SET, 32'h0000_0004, OKAY);
    read_check(A_SET, 32'h0000_0FFF, OKAY);
    $display("Test write protection done");
  endtask

  task automatic test_unmapped();
    write_check(A_BAD, 32'h0000_0FFF, SLV);
    read_check(A_BAD, 32'h0000_0000, SLV);
    read_check(A_SET, 32'h0000_0FFF, OKAY);
    $display("Test unmapped address done");
  endtask

  task automatic test_irq();
    write_check(A_CLR, 32'h0000_0FFF, OKAY);
    // Only byte lane 1 enabled, so bits 11..8 alone may change
    wstrb <= 4'h2;
    write_check(A_SET, 32'h0000_0FFF, OKAY);
    read_check(A_SET, 32'h0000_0F00, OKAY);
    wstrb <= 4'hF;
    write_check(A_CLR, 32'h0000_0F00, OKAY);
    write_check(A_SET, 32'h0000_00A5, OKAY);
    src_status <= 12'h0FF;
    wait_irq(1'b1);
    repeat (3) @(posedge aclk);
    check_word({20'h0_0000, irq_req}, 32'h0000_00A5, "irq_req");
    read_check(A_FLG, 32'h0000_00FF, OKAY);
    write_check(A_FLG, 32'h0000_0005, OKAY);
    repeat (2) @(posedge aclk);
    check_word({20'h0_0000, irq_req}, 32'h0000_00A0, "irq_req");
    // Source still high, so a cleared flag must not come back
    read_check(A_FLG, 32'h0000_00FA, OKAY);
    write_check(A_CLR, 32'h0000_00A0, OKAY);
    wait_irq(1'b0);
    check_word({20'h0_0000, irq_req}, 32'h0000_0000, "irq_req");
    src_status <= 12'h000;
    repeat (6) @(posedge aclk);
    write_check(A_FLG, 32'h0000_0FFF, OKAY);
    read_check(A_FLG, 32'h0000_0000, OKAY);
    $display("Test interrupt path done");
  endtask

  // A reset in mid-run must wipe the mask set just before it
  task automatic test_mid_reset();
    write_check(A_SET, 32'h0000_0F0F, OKAY);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    read_check(A_SET, 32'h0000_0000, OKAY);
    read_check(A_FLG, 32'h0000_0000, OKAY);
    check_word({20'h0_0000, irq_req}, 32'h0000_0000, "irq_req");
    $display("Test mid-run reset done");
  endtask

  initial begin
    aclk = 1'b0;
    aresetn <= 1'b0;
    awaddr <= 32'h0000_0000;
    awvalid <= 1'b0;
    wdata <= 32'h0000_0000;
    wstrb <= 4'hF;
    wvalid <= 1'b0;
    bready <= 1'b0;
    araddr <= 32'h0000_0000;
    arvalid <= 1'b0;
    rready <= 1'b0;
    src_status <= 12'h000;
    failures = 0;
    tests_run = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    test_reset();
    test_set_bits();
    test_clear_view();
    test_protect();
    test_unmapped();
    test_irq();
    test_mid_reset();
    test_done();
  end

endmodule
